// ===== src/mcf_frame_link.sv
// Summary of operation
// - Device only answers received commands
// - Execute first, then send one reply; bad checksum replied at once, unexecuted
// - Drive bus only while replying
// - Core is cmd, type, bank, value
// - Serial frame adds address and checksum
// - Value field sent MSB first
// - Command checksum sums all prior bytes
// - CAN commands lack address and checksum
// - CAN reply lacks address and checksum
// - Reply order fixed; status 100 success
// - Reply checksum is wrapping byte sum
// - Status codes 100,1,2..6 as defined
`timescale 1ns/10ps
`default_nettype none
`include "mcf_regs.svh"
module mcf_frame_link (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Configuration
	input wire logic can_mode,
	input wire logic [7:0] module_addr,
	input wire logic [7:0] reply_addr,
	// Received byte stream from the link
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	// Command to the executor
	output logic cmd_valid,
	output logic [7:0] cmd_number,
	output logic [7:0] cmd_type,
	output logic [7:0] cmd_bank,
	output logic [31:0] cmd_value,
	// Result from the executor
	input wire logic res_valid,
	input wire logic [7:0] res_status,
	input wire logic [31:0] res_value,
	// Transmit byte stream to the link
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_byte,
	output logic tx_enable
);
	import mcf_pkg::*;

	// ==========================================
	// Helpers
	function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] i);
		// MSB first: index 0 is bits 31:24
		pick_byte = w[8'(31 - 8 * i) -: 8];
	endfunction

	// ==========================================
	// State
	mcf_state_type state, next_state;
	logic [3:0] count, next_count;
	logic [7:0] sum, next_sum;
	logic [7:0] frame [0:8];
	logic [7:0] next_frame [0:8];
	logic [7:0] status, next_status;
	logic [31:0] value, next_value;
	logic [7:0] out_byte, next_out_byte;
	logic cmd_pulse, next_cmd_pulse;

	logic [3:0] len;
	logic [3:0] rlen;
	logic [3:0] core;
	logic last_rx;
	// serial frames carry address and checksum
	assign len = can_mode ? `MCF_CAN_LEN : `MCF_SER_LEN;
	// CAN reply drops address and checksum
	assign rlen = can_mode ? `MCF_CAN_RPL_LEN : `MCF_SER_RPL_LEN;
	// CAN frames start directly with the command core
	assign core = can_mode ? 4'd0 : 4'd1;
	assign last_rx = rx_valid && (count == len - 4'd1);

	// Reply byte at position count, checksum taken from running sum
	function automatic logic [7:0] reply_byte(input logic [3:0] k, input logic cm, input logic [7:0] ra,
		input logic [7:0] ma, input logic [7:0] st, input logic [7:0] cn, input logic [31:0] v,
		input logic [7:0] s);
		logic [3:0] j;
		j = cm ? k + 4'd2 : k;
		case (j)
			4'd0: reply_byte = ra;
			4'd1: reply_byte = ma;
			4'd2: reply_byte = st;
			4'd3: reply_byte = cn;
			4'd4, 4'd5, 4'd6, 4'd7: reply_byte = pick_byte(v, 2'(j - 4'd4));
			default: reply_byte = s;
		endcase
	endfunction

	always_comb begin
		next_state = state;
		next_count = count;
		next_sum = sum;
		next_frame = frame;
		next_status = status;
		next_value = value;
		next_out_byte = out_byte;
		next_cmd_pulse = 1'b0;
		case (state)
			MCF_RX: begin
				// nothing leaves the device until a full frame arrives
				if (rx_valid) begin
					next_frame[count] = rx_byte;
					next_count = count + 4'd1;
					// modulo-256 sum over every byte before the checksum
					next_sum = sum + rx_byte;
					if (last_rx) begin
						next_count = 4'd0;
						next_sum = 8'h00;
						if (!can_mode && frame[`MCF_POS_ADDR] != module_addr) begin
							next_state = MCF_RX;
						end else if (!can_mode && rx_byte != sum) begin
							next_status = `MCF_ST_CSUM;
							next_value = 32'h0000_0000;
							next_state = MCF_TX;
						end else begin
							next_cmd_pulse = 1'b1;
							next_state = MCF_EXEC;
						end
					end
				end
			end
			MCF_EXEC: begin
				// the reply waits for the executor's result
				if (res_valid) begin
					next_status = res_status;
					next_value = res_value;
					next_state = MCF_TX;
				end
			end
			MCF_TX: begin
				// reply order; CAN skips address and checksum
				next_out_byte = reply_byte(count, can_mode, reply_addr, module_addr, status,
					frame[core], value, sum);
				next_state = MCF_DONE;
			end
			MCF_DONE: begin
				if (tx_ready) begin
					// wrapping sum of the bytes already sent
					next_sum = sum + out_byte;
					next_count = count + 4'd1;
					next_state = MCF_TX;
					if (count == rlen - 4'd1) begin
						next_count = 4'd0;
						next_sum = 8'h00;
						next_state = MCF_RX;
					end
				end
			end
			default: begin
				next_state = MCF_RX;
				next_count = 4'd0;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= MCF_RX;
			count <= 4'd0;
			sum <= 8'h00;
			status <= `MCF_ST_OK;
			value <= 32'h0000_0000;
			out_byte <= 8'h00;
			cmd_pulse <= 1'b0;
			for (int i = 0; i < 9; i++) begin
				frame[i] <= 8'h00;
			end
		end else begin
			state <= next_state;
			count <= next_count;
			sum <= next_sum;
			status <= next_status;
			value <= next_value;
			out_byte <= next_out_byte;
			cmd_pulse <= next_cmd_pulse;
			frame <= next_frame;
		end
	end

	// ==========================================
	// Outputs
	// core fields; value assembled MSB first
	assign cmd_valid = cmd_pulse;
	// command number kept for the reply echo
	assign cmd_number = frame[core];
	assign cmd_type = frame[core + 4'd1];
	assign cmd_bank = frame[core + 4'd2];
	assign cmd_value = {frame[core + 4'd3], frame[core + 4'd4], frame[core + 4'd5], frame[core + 4'd6]};
	assign tx_enable = (state == MCF_TX) || (state == MCF_DONE);
	assign tx_valid = (state == MCF_DONE);
	assign tx_byte = out_byte;

	// ==========================================
	// Checks
	sequence frame_end_s;
		rx_valid && (state == MCF_RX) && (count == len - 4'd1);
	endsequence

	no_idle_tx_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state == MCF_RX) |-> !tx_enable) else $error("bus driven outside reply");
	// Bus is released only after the last reply byte was taken
	drive_end_a: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(tx_enable) |-> $past(tx_valid && tx_ready && count == rlen - 4'd1))
		else $error("bus released early");
	// A reply starts after a result, or at once after a bad checksum
	exec_before_reply_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(tx_enable) |-> $past(res_valid) || $past(last_rx && !can_mode && rx_byte != sum))
		else $error("reply before result");
	foreign_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
		frame_end_s ##0 (!can_mode && frame[0] != module_addr) |=> (state == MCF_RX))
		else $error("foreign frame answered");
	bad_sum_a: assert property (@(posedge ref_clk) disable iff (rst)
		frame_end_s ##0 (!can_mode && frame[0] == module_addr && rx_byte != sum) |=>
		(state == MCF_TX) && (status == 8'h01)) else $error("checksum error missed");
	good_cmd_a: assert property (@(posedge ref_clk) disable iff (rst)
		frame_end_s ##0 (can_mode || (frame[0] == module_addr && rx_byte == sum)) |=> cmd_valid)
		else $error("good command not issued");
	reply_first_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state == MCF_EXEC && res_valid && !can_mode) |=> ##1 (tx_byte == reply_addr))
		else $error("reply address not first");
	reply_sum_a: assert property (@(posedge ref_clk) disable iff (rst)
		(tx_valid && !can_mode && count == 4'd8) |-> (tx_byte == sum)) else $error("reply checksum wrong");
	echo_cmd_a: assert property (@(posedge ref_clk) disable iff (rst)
		(tx_valid && count == (can_mode ? 4'd1 : 4'd3)) |-> (tx_byte == cmd_number))
		else $error("command number not echoed");
endmodule
`default_nettype wire

// ===== src/mcf_regs.svh
`ifndef MCF_REGS_SVH
`define MCF_REGS_SVH
// Frame lengths in bytes
`define MCF_SER_LEN 4'd9
`define MCF_CAN_LEN 4'd7
// Reply lengths in bytes
`define MCF_SER_RPL_LEN 4'd9
`define MCF_CAN_RPL_LEN 4'd6
// Status codes
`define MCF_ST_OK 8'h64
`define MCF_ST_CSUM 8'h01
`define MCF_ST_BADCMD 8'h02
// Byte positions inside a serial command frame
`define MCF_POS_ADDR 4'd0
`define MCF_POS_CSUM 4'd8
// Reset value of the configured address
`define MCF_ADDR_RST 8'h01
`endif

// ===== src/mcf_pkg.sv
package mcf_pkg;
	typedef enum logic [3:0] {
		MCF_RX = 4'b0001,
		MCF_EXEC = 4'b0010,
		MCF_TX = 4'b0100,
		MCF_DONE = 4'b1000
	} mcf_state_type;
endpackage

// ===== verif/mcf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Host end of the link: collects reply bytes
module mcf_host_model (
	// Clock
	input wire logic ref_clk,
	// Stall request from the bench
	input wire logic slow,
	// Reply stream
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte,
	output logic tx_ready
);
	logic [7:0] got [$];
	logic [1:0] t = 2'b00;
	initial tx_ready = 1'b0;
	// whole reply taken before next command
	always @(posedge ref_clk) begin
		if (tx_valid && tx_ready)
			got.push_back(tx_byte);
		t <= t + 2'b01;
		// Slow mode accepts only one edge in four
		tx_ready <= #1 (!slow || t == 2'b11);
	end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic ref_clk, rst, can_mode, rx_valid, res_valid, slow, cmd_valid, tx_valid, tx_ready, tx_enable;
	logic [7:0] module_addr, reply_addr, rx_byte, res_status, cmd_number, cmd_type, cmd_bank, tx_byte;
	logic [31:0] res_value, cmd_value;
	int failures = 0;
	int n_tests = 0;
	int seen_cmd = 0;
	mcf_frame_link dut_u (.ref_clk(ref_clk), .rst(rst), .can_mode(can_mode), .module_addr(module_addr),
		.reply_addr(reply_addr), .rx_valid(rx_valid), .rx_byte(rx_byte), .cmd_valid(cmd_valid),
		.cmd_number(cmd_number), .cmd_type(cmd_type), .cmd_bank(cmd_bank), .cmd_value(cmd_value),
		.res_valid(res_valid), .res_status(res_status), .res_value(res_value), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_byte(tx_byte), .tx_enable(tx_enable));
	mcf_host_model host_u (.ref_clk(ref_clk), .slow(slow), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.tx_ready(tx_ready));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========
	// Executor stand-in: inverted value, status from the bench
	always @(posedge ref_clk) begin
		if (cmd_valid) begin
			seen_cmd++;
			repeat (3) @(posedge ref_clk);
			#1 res_valid = 1'b1;
			res_value = ~cmd_value;
			@(posedge ref_clk);
			#1 res_valid = 1'b0;
		end
	end
	// ==========
	// One exchange: send a frame, collect and judge the reply
	task automatic frame(input logic cm, input logic [7:0] adr, input logic [7:0] bad, input int nrep,
		input logic [7:0] st);
		logic [7:0] f [$];
		logic [7:0] e [$];
		logic [31:0] v;
		logic [7:0] s;
		int k;
		int c0;
		host_u.got.delete();
		c0 = seen_cmd;
		can_mode = cm;
		f = '{adr, 8'h05, 8'h04, 8'h00, 8'h12, 8'h34, 8'h56, 8'hf0};
		s = 8'h00;
		foreach (f[i]) s += f[i];
		f.push_back(s + bad);
		if (cm)
			f = f[1:7];
		foreach (f[i]) begin
			rx_valid = 1'b1;
			rx_byte = f[i];
			@(posedge ref_clk);
			#1;
		end
		rx_valid = 1'b0;
		k = 0;
		// next command only after the whole reply
		while (k < 200 && (nrep == 0 || host_u.got.size() < nrep || tx_enable)) begin
			@(posedge ref_clk);
			#1 k++;
		end
		v = (st == 8'h64) ? ~32'h1234_56f0 : 32'h0000_0000;
		e = '{reply_addr, module_addr, st, 8'h05, v[31:24], v[23:16], v[15:8], v[7:0]};
		s = 8'h00;
		foreach (e[i]) s += e[i];
		e.push_back(s);
		if (cm)
			e = e[2:7];
		check(host_u.got.size(), nrep);
		check(tx_enable, 1'b0);
		check(tx_valid, 1'b0);
		check(seen_cmd - c0, (st == 8'h64 && nrep > 0) ? 1 : 0);
		for (int i = 0; i < e.size() && i < nrep; i++)
			check(host_u.got[i], e[i]);
		if (seen_cmd != c0)
			check({cmd_number, cmd_type, cmd_bank}, 24'h05_0400);
		if (seen_cmd != c0)
			check(cmd_value, 32'h1234_56f0);
		$display("test done can=%0d addr=%h status=%h", cm, adr, st);
	endtask
	// ==========
	// Scenarios
	task automatic test_good_serial();
		frame(1'b0, 8'h01, 8'h00, 9, 8'h64);
	endtask
	task automatic test_bad_sum();
		// corrupted checksum answered with status 1
		frame(1'b0, 8'h01, 8'h01, 9, 8'h01);
	endtask
	task automatic test_foreign();
		// frame for another module stays silent
		frame(1'b0, 8'h07, 8'h00, 0, 8'h64);
	endtask
	task automatic test_slow_host();
		slow = 1'b1;
		frame(1'b0, 8'h01, 8'h00, 9, 8'h64);
	endtask
	task automatic test_can();
		frame(1'b1, 8'h01, 8'h00, 6, 8'h64);
	endtask
	// Reset lands as soon as a reply starts driving the bus, before its first byte is offered
	task automatic test_mid_reset();
		logic [7:0] f [$];
		int k;
		host_u.got.delete();
		can_mode = 1'b0;
		f = '{8'h01, 8'h05, 8'h04, 8'h00, 8'h12, 8'h34, 8'h56, 8'hf0, 8'h96};
		foreach (f[i]) begin
			rx_valid = 1'b1;
			rx_byte = f[i];
			@(posedge ref_clk);
			#1;
		end
		rx_valid = 1'b0;
		k = 0;
		while (k < 50 && !tx_enable) begin
			@(posedge ref_clk);
			#1 k++;
		end
		check(tx_enable, 1'b1);
		rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		check(tx_enable, 1'b0);
		check(tx_valid, 1'b0);
		check(cmd_valid, 1'b0);
		check({cmd_number, cmd_type, cmd_bank}, 24'h00_0000);
		check(cmd_value, 32'h0000_0000);
		rst = 1'b0;
		$display("test done mid-reply reset");
	endtask
	initial begin
		{rst, can_mode, rx_valid, res_valid, slow, rx_byte} = {5'b10000, 8'h00};
		{module_addr, reply_addr, res_status, res_value} = {8'h01, 8'h02, 8'h64, 32'h0000_0000};
		repeat (4) @(posedge ref_clk);
		#1 rst = 1'b0;
		test_good_serial();
		test_bad_sum();
		test_foreign();
		test_slow_host();
		test_mid_reset();
		test_can();
		end_of_test();
	end
	initial begin
		#100000;
		failures++;
		end_of_test();
	end
endmodule
`default_nettype wire
